/* File: core/oc_alert_pkg.sv */
package oc_alert_pkg;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int WINDOW_US = 10;
  localparam int WINDOW_CYCLES = WINDOW_US * CLK_MHZ;
  localparam int LATCH_CLEAR_US = 20;
  localparam int LATCH_CLEAR_CYCLES = LATCH_CLEAR_US * CLK_MHZ;
  localparam int WIN_W = 16;
  localparam int LCLR_W = 12;
  localparam int CNT_W = 4;

  // consecutive windows needed per delay setting
  localparam logic [3:0] TARGET_SHORT = 4'h1;
  localparam logic [3:0] TARGET_MID = 4'h5;
  localparam logic [3:0] TARGET_LONG = 4'hA;

  // three-level pin codes: floating, ground, supply
  localparam logic [1:0] LEVEL_FLOAT = 2'h0;
  localparam logic [1:0] LEVEL_GND = 2'h1;
  localparam logic [1:0] LEVEL_SUPPLY = 2'h2;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WINDOW = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // reset values
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [WIN_W-1:0] WINDOW_RESET = WIN_W'(WINDOW_CYCLES);
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // status fields
  localparam int ST_ALERT = 0;
  localparam int ST_LAST_OVER = 1;
  localparam int ST_LATCH = 2;
  localparam int ST_ACTIVE = 3;
  localparam int ST_COUNT_LSB = 4;
  localparam int ST_DELAY_LSB = 8;
  localparam int ST_HYS_LSB = 10;

  // interrupt status bits
  localparam int IRQ_ASSERT = 0;
  localparam int IRQ_RELEASE = 1;
  localparam int IRQ_OVER = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/overcurrent_alert_qualifier.sv */
`timescale 1ns/1ps
module overcurrent_alert_qualifier (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic over_limit_pin, // front-end decision, high = averaged input over limit
  input wire logic delay_pin_gnd, // delay pin level detector: tied to ground
  input wire logic delay_pin_supply, // delay pin level detector: tied to supply
  input wire logic hys_pin_gnd, // hysteresis_select_pin detector: tied to ground
  input wire logic hys_pin_supply, // hysteresis_select_pin detector: tied to supply
  input wire logic latch_pin, // high = latch mode, low = transparent / clear
  input wire logic enable_pin, // high = enabled
  output logic alert_n_out, // open-drain alert data, always low
  output logic alert_n_oe, // high while the alert pin is pulled low
  output logic [1:0] hys_code, // hysteresis to comparator: 0=2mV 1=4mV 2=8mV
  output logic irq, // level interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  localparam int NPIN = 7;
  localparam int CW = oc_alert_pkg::CNT_W;
  localparam int WW = oc_alert_pkg::WIN_W;
  localparam int LW = oc_alert_pkg::LCLR_W;

  logic [NPIN-1:0] pins_sync;
  logic over_s;
  logic dly_gnd_s;
  logic dly_sup_s;
  logic hys_gnd_s;
  logic hys_sup_s;
  logic latch_s;
  logic enable_s;
  logic window_end;

  logic ctrl_enable;
  logic [WW-1:0] window_len;
  logic [oc_alert_pkg::IRQ_W-1:0] irq_status;
  logic [oc_alert_pkg::IRQ_W-1:0] irq_mask;

  logic [1:0] delay_code;
  logic [CW-1:0] target;
  logic [CW-1:0] win_count;
  logic alert;
  logic last_over;
  logic active;
  logic [LW-1:0] latch_low_count;
  logic latch_low_done;
  logic ev_assert;
  logic ev_release;
  logic ev_over;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic ar_take;
  logic rd_irq;
  logic [31:0] status_word;

  // all pins come from outside the clock domain
  pin_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_in({enable_pin, latch_pin, hys_pin_supply, hys_pin_gnd,
             delay_pin_supply, delay_pin_gnd, over_limit_pin}),
    .pin_out(pins_sync)
  );
  assign {enable_s, latch_s, hys_sup_s, hys_gnd_s, dly_sup_s, dly_gnd_s, over_s} = pins_sync;

  window_timer #(
    .WIDTH(WW)
  ) u_window (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .period(window_len),
    .window_end(window_end)
  );

  // the board drives exactly one level; a conflicting pair reads as ground
  assign delay_code = dly_gnd_s ? oc_alert_pkg::LEVEL_GND :
                      dly_sup_s ? oc_alert_pkg::LEVEL_SUPPLY :
                      oc_alert_pkg::LEVEL_FLOAT;

  always_comb begin
    case (delay_code)
      oc_alert_pkg::LEVEL_GND: target = oc_alert_pkg::TARGET_MID;
      oc_alert_pkg::LEVEL_SUPPLY: target = oc_alert_pkg::TARGET_LONG;
      default: target = oc_alert_pkg::TARGET_SHORT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hys_code <= oc_alert_pkg::LEVEL_FLOAT;
    end else if (hys_gnd_s) begin
      hys_code <= oc_alert_pkg::LEVEL_GND;
    end else if (hys_sup_s) begin
      hys_code <= oc_alert_pkg::LEVEL_SUPPLY;
    end else begin
      hys_code <= oc_alert_pkg::LEVEL_FLOAT;
    end
  end

  assign active = enable_s & ctrl_enable;

  // decision sampled only at window end, so onset latency varies by up to one window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_over <= 1'b0;
    end else if (!active) begin
      last_over <= 1'b0;
    end else if (window_end) begin
      last_over <= over_s;
    end
  end

  // consecutive over-limit windows
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_count <= '0;
    end else if (!active) begin
      win_count <= '0;
    end else if (window_end) begin
      if (!over_s) begin
        win_count <= '0;
      end else if (win_count >= target) begin
        win_count <= target;
      end else begin
        win_count <= win_count + CW'(1);
      end
    end
  end

  // latch clear needs the pin held low for the minimum time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      latch_low_count <= '0;
    end else if (latch_s) begin
      latch_low_count <= '0;
    end else if (!latch_low_done) begin
      latch_low_count <= latch_low_count + LW'(1);
    end
  end
  assign latch_low_done = (latch_low_count >= LW'(oc_alert_pkg::LATCH_CLEAR_CYCLES));

  assign ev_assert = active & window_end & over_s & !alert &
                     ((win_count + CW'(1)) >= target);
  // a miss at window end with the latch pin low for the clear time releases; also after a late latch clear
  assign ev_release = alert & !latch_s & latch_low_done &
                      ((window_end & !over_s) | (!window_end & !last_over));
  assign ev_over = active & window_end & over_s;

  // disabling ends the alert as the part powers down
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alert <= 1'b0;
    end else if (!active) begin
      alert <= 1'b0;
    end else if (ev_assert) begin
      alert <= 1'b1;
    end else if (ev_release) begin
      alert <= 1'b0; // (a miss changes nothing unless release applies)
    end
  end

  // open drain: data stays low, enable pulls the line
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alert_n_out <= 1'b0;
      alert_n_oe <= 1'b0;
    end else begin
      alert_n_out <= 1'b0;
      alert_n_oe <= (alert & active & !ev_release) | ev_assert;
    end
  end

  // register bus
  assign do_write = aw_held & w_held & !s_axi_bvalid;
  assign next_aw_held = (aw_held | (s_axi_awvalid & s_axi_awready)) & !do_write;
  assign next_w_held = (w_held | (s_axi_wvalid & s_axi_wready)) & !do_write;
  assign next_bvalid = do_write | (s_axi_bvalid & !s_axi_bready);
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_take | (s_axi_rvalid & !s_axi_rready);
  assign rd_irq = ar_take & (s_axi_araddr == oc_alert_pkg::ADDR_IRQ_STATUS);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held & !next_bvalid;
      s_axi_wready <= !next_w_held & !next_bvalid;
      s_axi_bvalid <= next_bvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bresp <= oc_alert_pkg::RESP_OKAY;
    end else if (do_write) begin
      case (aw_addr)
        oc_alert_pkg::ADDR_CTRL, oc_alert_pkg::ADDR_WINDOW, oc_alert_pkg::ADDR_STATUS,
        oc_alert_pkg::ADDR_IRQ_STATUS, oc_alert_pkg::ADDR_IRQ_MASK:
          s_axi_bresp <= oc_alert_pkg::RESP_OKAY;
        default: s_axi_bresp <= oc_alert_pkg::RESP_SLVERR;
      endcase
    end
  end

  // writable controls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_enable <= oc_alert_pkg::CTRL_ENABLE_RESET;
      window_len <= oc_alert_pkg::WINDOW_RESET;
      irq_mask <= oc_alert_pkg::IRQ_MASK_RESET;
    end else if (do_write) begin
      if (aw_addr == oc_alert_pkg::ADDR_CTRL && w_strb[0]) begin
        ctrl_enable <= w_data[0];
      end
      if (aw_addr == oc_alert_pkg::ADDR_WINDOW) begin
        if (w_strb[0]) begin
          window_len[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          window_len[15:8] <= w_data[15:8];
        end
      end
      if (aw_addr == oc_alert_pkg::ADDR_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[oc_alert_pkg::IRQ_W-1:0];
      end
    end
  end

  // read clears, but an event in the same cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
    end else begin
      irq_status <= (rd_irq ? '0 : irq_status) | {ev_over, ev_release & alert, ev_assert};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[oc_alert_pkg::ST_ALERT] = alert;
    status_word[oc_alert_pkg::ST_LAST_OVER] = last_over;
    status_word[oc_alert_pkg::ST_LATCH] = latch_s;
    status_word[oc_alert_pkg::ST_ACTIVE] = active;
    status_word[oc_alert_pkg::ST_COUNT_LSB +: CW] = win_count;
    status_word[oc_alert_pkg::ST_DELAY_LSB +: 2] = delay_code;
    status_word[oc_alert_pkg::ST_HYS_LSB +: 2] = hys_code;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= oc_alert_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rresp <= oc_alert_pkg::RESP_OKAY;
        case (s_axi_araddr)
          oc_alert_pkg::ADDR_CTRL: s_axi_rdata <= {31'h00000000, ctrl_enable};
          oc_alert_pkg::ADDR_WINDOW: s_axi_rdata <= {16'h0000, window_len};
          oc_alert_pkg::ADDR_STATUS: s_axi_rdata <= status_word;
          oc_alert_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {29'h00000000, irq_status};
          oc_alert_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= oc_alert_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // asynchronous pins
  output logic [WIDTH-1:0] pin_out // synchronised levels
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          stage1[i] <= 1'b0;
          pin_out[i] <= 1'b0;
        end else begin
          stage1[i] <= pin_in[i];
          pin_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

/* File: core/window_timer.sv */
`timescale 1ns/1ps
module window_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [WIDTH-1:0] period, // window length in cycles
  output logic window_end // one-cycle pulse at each window end
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] last;

  // a zero period is treated as one cycle so the window never stalls
  assign last = (period == '0) ? '0 : period - WIDTH'(1);

  // free running: no start, stop or alignment input exists
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      window_end <= 1'b0;
    end else if (count >= last) begin
      count <= '0;
      window_end <= 1'b1;
    end else begin
      count <= count + WIDTH'(1);
      window_end <= 1'b0;
    end
  end
endmodule

/* File: testbench/oc_alert_checker.sv */
`timescale 1ns/1ps
module oc_alert_checker (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic over_limit_pin, // front-end decision
  input wire logic latch_pin, // latch mode pin
  input wire logic enable_pin, // enable pin
  input wire logic hys_pin_gnd, // hysteresis pin at ground
  input wire logic hys_pin_supply, // hysteresis pin at supply
  input wire logic alert_n_out, // alert data
  input wire logic alert_n_oe, // alert drive enable
  input wire logic [1:0] hys_code, // hysteresis to comparator
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid // read data valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_ALERT_LOW: assert property (alert_n_oe |-> alert_n_out == 1'h0)
    else $error("alert driven without pulling low");
  // pin passes two sync flops, so a rise needs the pin high within the last few edges
  AST_NO_ALERT_WITHOUT_OVER: assert property (!over_limit_pin [*8] |-> !$rose(alert_n_oe))
    else $error("alert asserted with input below limit");
  AST_OE_NEEDS_ENABLE: assert property ($rose(alert_n_oe) |-> $past(enable_pin, 3))
    else $error("alert asserted while disabled");
  AST_DISABLE_RELEASES: assert property (!enable_pin [*6] |-> !alert_n_oe)
    else $error("alert held while disabled");
  AST_HYS_FLOAT: assert property ((!hys_pin_gnd && !hys_pin_supply) [*6] |-> hys_code == 2'h0)
    else $error("hysteresis code wrong for floating pin");
  AST_HYS_GND: assert property ((hys_pin_gnd && !hys_pin_supply) [*6] |-> hys_code == 2'h1)
    else $error("hysteresis code wrong for ground pin");
  AST_HYS_SUPPLY: assert property ((!hys_pin_gnd && hys_pin_supply) [*6] |-> hys_code == 2'h2)
    else $error("hysteresis code wrong for supply pin");
  AST_LATCH_HOLDS: assert property ((latch_pin && enable_pin) [*6] ##0 alert_n_oe |=> alert_n_oe)
    else $error("latched alert released while latch pin high");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule

/* File: testbench/sense_controller_model.sv */
`timescale 1ns/1ps
module sense_controller_model (
  input wire logic over_cmd, // averaged input above limit
  input wire logic latch_cmd, // controller asks for latch mode
  input wire logic [1:0] delay_lvl, // board strap of delay pin
  input wire logic [1:0] hys_lvl, // board strap of hysteresis pin
  input wire logic alert_n_out, // alert data from device
  input wire logic alert_n_oe, // alert drive from device
  output logic over_limit_pin, // front-end decision
  output logic latch_pin, // latch pin level
  output logic delay_pin_gnd, // delay pin tied to ground
  output logic delay_pin_supply, // delay pin tied to supply
  output logic hys_pin_gnd, // hysteresis pin tied to ground
  output logic hys_pin_supply, // hysteresis pin tied to supply
  output logic alert_line // resolved alert wire
);
  // a strap is exactly one level, so never both detectors at once
  assign delay_pin_gnd = (delay_lvl == oc_alert_pkg::LEVEL_GND);
  assign delay_pin_supply = (delay_lvl == oc_alert_pkg::LEVEL_SUPPLY);
  assign hys_pin_gnd = (hys_lvl == oc_alert_pkg::LEVEL_GND);
  assign hys_pin_supply = (hys_lvl == oc_alert_pkg::LEVEL_SUPPLY);
  assign latch_pin = latch_cmd;
  assign over_limit_pin = over_cmd;
  // pull-up: a released wire reads high, not the last driven value
  assign alert_line = alert_n_oe ? alert_n_out : 1'h1;
endmodule

/* File: testbench/tb_overcurrent_alert_qualifier.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_overcurrent_alert_qualifier;
  localparam int WIN = 16;
  localparam logic [1:0] RSP_OK = oc_alert_pkg::RESP_OKAY;
  localparam logic [1:0] RSP_ERR = oc_alert_pkg::RESP_SLVERR;
  logic clk_sys, rst_b = 1'h0, over_cmd = 1'h0, latch_cmd = 1'h0, enable_pin = 1'h1;
  logic [1:0] delay_lvl = 2'h0, hys_lvl = 2'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic over_limit_pin, latch_pin, delay_pin_gnd, delay_pin_supply, hys_pin_gnd, hys_pin_supply;
  logic alert_n_out, alert_n_oe, irq, alert_line, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] hys_code, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0, samples_checked = 0;

  overcurrent_alert_qualifier u_overcurrent_alert_qualifier (.clk_sys, .rst_b, .over_limit_pin,
    .delay_pin_gnd, .delay_pin_supply, .hys_pin_gnd, .hys_pin_supply, .latch_pin, .enable_pin,
    .alert_n_out, .alert_n_oe, .hys_code, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sense_controller_model u_sense_controller_model (.over_cmd, .latch_cmd, .delay_lvl, .hys_lvl,
    .alert_n_out, .alert_n_oe, .over_limit_pin, .latch_pin, .delay_pin_gnd, .delay_pin_supply,
    .hys_pin_gnd, .hys_pin_supply, .alert_line);

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic guard(input bit ok);
    if (!ok) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic hold(input int n, input logic e);
    repeat (n) begin
      @(posedge clk_sys);
      `CHK(alert_line, e)
    end
  endtask

  task automatic wait_alert(input logic e, input int n);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (alert_line !== e && i < n);
    `CHK(alert_line, e)
    guard(alert_line === e);
  endtask

  // address and data offered together; bready held until the response edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int i;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && i < 100);
    guard(s_axi_bvalid === 1'h1);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int i;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && i < 100);
    guard(s_axi_rvalid === 1'h1);
    `CHK(s_axi_rresp, er)
    v = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask

  task automatic t_regs();
    logic [31:0] v;
    axi_rd(oc_alert_pkg::ADDR_CTRL, RSP_OK, v);
    `CHK(v[0], oc_alert_pkg::CTRL_ENABLE_RESET)
    axi_rd(oc_alert_pkg::ADDR_WINDOW, RSP_OK, v);
    `CHK(v[15:0], oc_alert_pkg::WINDOW_RESET)
    axi_rd(oc_alert_pkg::ADDR_IRQ_MASK, RSP_OK, v);
    `CHK(v[2:0], oc_alert_pkg::IRQ_MASK_RESET)
    axi_rd(8'h14, RSP_ERR, v);
    `CHK(v, 32'h0)
    axi_wr(8'h14, 32'hFFFFFFFF, RSP_ERR);
    // soft enable off must drop the active flag, and back on must restore it
    axi_wr(oc_alert_pkg::ADDR_CTRL, 32'h0, RSP_OK);
    axi_rd(oc_alert_pkg::ADDR_STATUS, RSP_OK, v);
    `CHK(v[3], 1'h0)
    axi_wr(oc_alert_pkg::ADDR_CTRL, 32'h1, RSP_OK);
    axi_rd(oc_alert_pkg::ADDR_STATUS, RSP_OK, v);
    `CHK(v[3], 1'h1)
    // a short window keeps the ten-window runs brief
    axi_wr(oc_alert_pkg::ADDR_WINDOW, 32'h10, RSP_OK);
    axi_rd(oc_alert_pkg::ADDR_WINDOW, RSP_OK, v);
    `CHK(v[15:0], 16'h10)
  endtask

  task automatic t_hys();
    for (int l = 0; l < 3; l++) begin
      hys_lvl <= 2'(l);
      tick(6);
      `CHK(hys_code, 2'(l))
    end
    hys_lvl <= oc_alert_pkg::LEVEL_FLOAT;
  endtask

  task automatic t_irq();
    logic [31:0] v;
    over_cmd <= 1'h1;
    wait_alert(1'h0, 40);
    `CHK(irq, 1'h0)
    axi_wr(oc_alert_pkg::ADDR_IRQ_MASK, 32'h1, RSP_OK);
    tick(3);
    `CHK(irq, 1'h1)
    axi_rd(oc_alert_pkg::ADDR_IRQ_STATUS, RSP_OK, v);
    `CHK(v[0], 1'h1)
    `CHK(v[2], 1'h1)
    tick(3);
    `CHK(irq, 1'h0)
    over_cmd <= 1'h0;
    wait_alert(1'h1, 60);
    axi_wr(oc_alert_pkg::ADDR_IRQ_MASK, 32'h2, RSP_OK);
    tick(3);
    `CHK(irq, 1'h1)
    axi_wr(oc_alert_pkg::ADDR_IRQ_MASK, 32'h0, RSP_OK);
  endtask

  // a short run below target must be forgotten, then a full run must trip on time
  task automatic t_delay(input logic [1:0] lvl, input int n);
    logic [31:0] v;
    delay_lvl <= lvl;
    tick(8);
    if (n > 1) begin
      over_cmd <= 1'h1;
      hold((n - 2) * WIN, 1'h1);
      over_cmd <= 1'h0;
      hold(24, 1'h1);
    end
    over_cmd <= 1'h1;
    // the earliest trip shows on the fourth edge of the last window, so only three are safe
    hold((n - 1) * WIN + 3, 1'h1);
    wait_alert(1'h0, 40);
    tick(3 * WIN);
    axi_rd(oc_alert_pkg::ADDR_STATUS, RSP_OK, v);
    `CHK(v[7:4], 4'(n))
    `CHK(v[9:8], lvl)
    over_cmd <= 1'h0;
    wait_alert(1'h1, 60);
  endtask

  task automatic t_disable();
    logic [31:0] v;
    delay_lvl <= oc_alert_pkg::LEVEL_GND;
    over_cmd <= 1'h1;
    hold(3 * WIN, 1'h1);
    enable_pin <= 1'h0;
    tick(8);
    axi_rd(oc_alert_pkg::ADDR_STATUS, RSP_OK, v);
    `CHK(v[7:4], 4'h0)
    enable_pin <= 1'h1;
    hold(4 * WIN + 3, 1'h1);
    wait_alert(1'h0, 40);
    enable_pin <= 1'h0;
    wait_alert(1'h1, 8);
    enable_pin <= 1'h1;
    over_cmd <= 1'h0;
  endtask

  task automatic t_latch();
    delay_lvl <= oc_alert_pkg::LEVEL_FLOAT;
    latch_cmd <= 1'h1;
    tick(4);
    over_cmd <= 1'h1;
    wait_alert(1'h0, 40);
    over_cmd <= 1'h0;
    hold(5 * WIN, 1'h0);
    latch_cmd <= 1'h0;
    hold(2400, 1'h0);
    wait_alert(1'h1, 200);
    // a latch clear while the input is still over must not release the alert
    latch_cmd <= 1'h1;
    tick(4);
    over_cmd <= 1'h1;
    wait_alert(1'h0, 40);
    latch_cmd <= 1'h0;
    hold(2600, 1'h0);
    over_cmd <= 1'h0;
    wait_alert(1'h1, 40);
  endtask

  initial begin
    tick(6);
    rst_b <= 1'h1;
    tick(2);
    t_regs();
    // transparent release also needs the latch pin low for the full clear time
    tick(2600);
    t_hys();
    t_irq();
    t_delay(oc_alert_pkg::LEVEL_FLOAT, 1);
    t_delay(oc_alert_pkg::LEVEL_GND, 5);
    t_delay(oc_alert_pkg::LEVEL_SUPPLY, 10);
    t_disable();
    t_latch();
    complete_run();
  end
endmodule

bind overcurrent_alert_qualifier oc_alert_checker u_oc_alert_checker (.clk_sys, .rst_b,
  .over_limit_pin, .latch_pin, .enable_pin, .hys_pin_gnd, .hys_pin_supply, .alert_n_out,
  .alert_n_oe, .hys_code, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
